/* File: pkg/alht_pkg.sv */
// Shared constants for the axis limit, home and trigger sequencer
package alht_pkg;
  localparam int NAX = 4;
  localparam int ENT_W = 42;
  localparam int EN_W = 12;
  localparam int EN_HOME_TOP = 11;
  localparam int EN_LIM_TOP = 7;
  localparam logic [11:0] EN_RST = 12'h000;
  localparam logic [11:0] POL_RST = 12'h000;
  localparam logic [2:0] LINK_RST = 3'h0;
  localparam logic [3:0] TRIG_EN_RST = 4'h0;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_LIMEN = 8'h0c;
  localparam logic [7:0] ADDR_SW = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_FE = 0;
  localparam int ST_FNE = 1;
  localparam int ST_STORE = 2;
  localparam int ST_SRCH = 3;
  localparam int ST_REPLAY = 4;
  localparam int ST_RUN = 8;
  localparam int ST_DIR = 12;
  localparam int ST_TRIG_EN = 16;
  localparam int ST_PEND = 20;
  localparam logic [7:0] OP_KILL = 8'h01;
  localparam logic [7:0] OP_STOP = 8'h02;
  localparam logic [7:0] OP_STOP_MODE = 8'h03;
  localparam logic [7:0] OP_RD_AXSTAT = 8'h04;
  localparam logic [7:0] OP_RD_POS = 8'h05;
  localparam logic [7:0] OP_RD_VEL = 8'h06;
  localparam logic [7:0] OP_SET_IO_OUT = 8'h07;
  localparam logic [7:0] OP_RD_IO = 8'h08;
  localparam logic [7:0] OP_RD_COMM = 8'h09;
  localparam logic [7:0] OP_SET_IO_POL = 8'h0a;
  localparam logic [7:0] OP_SET_LIM_POL = 8'h0b;
  localparam logic [7:0] OP_RD_LIM = 8'h0c;
  localparam logic [7:0] OP_RD_ADC = 8'h0d;
  localparam logic [7:0] OP_RD_GPIO = 8'h0e;
  localparam logic [7:0] OP_SET_GPIO = 8'h0f;
  localparam logic [7:0] OP_EN_LIMITS = 8'h10;
  localparam logic [7:0] OP_BRK_LINK = 8'h11;
  localparam logic [7:0] OP_BEGIN_PRE = 8'h12;
  localparam logic [7:0] OP_END_PRE = 8'h13;
  localparam logic [7:0] OP_TRIG_SW = 8'h14;
  localparam logic [7:0] OP_FIND_HOME = 8'h15;
  localparam logic [7:0] OP_EN_BRK = 8'h16;
  localparam logic [7:0] OP_LOAD_BRK = 8'h17;
  localparam logic [7:0] OP_LOAD_VEL = 8'h18;
  localparam logic [7:0] OP_LOAD_ACC = 8'h19;
  localparam logic [7:0] OP_EN_IO_TRIG = 8'h1a;
  localparam logic [7:0] OP_MOVE = 8'h1b;
  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_OUT = 2'b01,
    SR_BACK = 2'b10
  } alht_srch_e;
  typedef enum logic [1:0] {
    RP_IDLE = 2'b00,
    RP_RUN = 2'b01
  } alht_rp_e;
endpackage

/* File: hdl/alht_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module alht_sync #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: hdl/alht_tbuf.sv */
// One trigger buffer: a list of stored commands in flip-flops
`timescale 1ns/1ns
module alht_tbuf #(
  parameter int DW = 42,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic we,
  input wire logic [DW-1:0] wd,
  input wire logic [CW-1:0] ridx,
  output logic [DW-1:0] rd,
  output logic [CW-1:0] count,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [DW-1:0] mem_r [DEPTH];
  logic [CW-1:0] count_r;

  // Read side and fill state
  assign full = (count_r == CW'(DEPTH));
  assign count = count_r;
  assign rd = mem_r[ridx[AW-1:0]];

  // Fill counter, cleared when a new list begins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= '0;
    end else if (we && !full) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Entry storage
  always_ff @(posedge clk_sys) begin
    if (we && !full && !clr) begin
      mem_r[count_r[AW-1:0]] <= wd;
    end
  end
endmodule

/* File: hdl/alht_axis_seq.sv */
// Four-axis limit gating, home search, breakpoint links and trigger buffers
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module alht_axis_seq #(
  parameter int POS_W = 32,
  parameter int TB_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] sw_fwd,
  input wire logic [3:0] sw_rev,
  input wire logic [3:0] sw_home,
  input wire logic [3:0] io_trig,
  input wire logic [4*POS_W-1:0] axis_pos,
  output logic [3:0] mot_run,
  output logic [3:0] mot_fwd,
  output logic [3:0] halt_stb,
  output logic [3:0] brk_out,
  output logic [127:0] mot_vel,
  output logic [127:0] mot_acc,
  output logic exec_valid,
  output logic [7:0] exec_op,
  output logic [1:0] exec_axis,
  output logic [31:0] exec_data
);
  localparam int NAX = alht_pkg::NAX;
  localparam int EW = alht_pkg::ENT_W;
  localparam int CW = $clog2(TB_DEPTH + 1);

  logic aw_hold_r, w_hold_r, wr_go, host_go, stat_clr;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, data_r, rd_mux;
  logic rd_ok;
  logic [3:0] w_strb_r;
  logic [15:0] s_pins;
  logic [3:0] s_fwd, s_rev, s_home, s_io, s_io_q_r;
  logic [11:0] limen_r, pol_r;
  logic [3:0] arm_fwd, arm_rev, arm_home, q_fwd_r, q_rev_r, q_home_r;
  logic [3:0] e_fwd, e_rev, e_home, halt_ev, blk;
  logic [EW-1:0] c_e;
  logic c_v, c_fwd, do_x, bad, fe_set, fne_set, mv_block, fh_dir;
  logic [7:0] c_op;
  logic [1:0] c_ax;
  logic [31:0] c_dt;
  logic fe_r, fne_r, store_r;
  logic [1:0] store_sel_r;
  logic [3:0] tb_clr, tb_we, tb_full, trig_en_r, pend_r, pend_set, pick_oh;
  logic [EW-1:0] tb_rd [NAX];
  logic [CW-1:0] tb_cnt [NAX];
  logic [1:0] pick, rp_buf_r;
  logic [CW-1:0] rp_idx_r;
  alht_pkg::alht_rp_e rp_st_r;
  alht_pkg::alht_srch_e sr_st_r;
  logic [1:0] sa_r;
  logic sd_r, sr_revgo;
  logic [2:0] link_r [NAX];
  logic [POS_W-1:0] brk_pos_r [NAX];
  logic [POS_W-1:0] brk_tgt_r [NAX];
  logic [3:0] brk_en_r, brk_hit;

  // Legal commands while a home search runs
  function automatic logic permit(input logic [7:0] op);
    case (op)
      alht_pkg::OP_KILL, alht_pkg::OP_STOP, alht_pkg::OP_STOP_MODE, alht_pkg::OP_RD_AXSTAT,
      alht_pkg::OP_RD_POS, alht_pkg::OP_RD_VEL, alht_pkg::OP_SET_IO_OUT, alht_pkg::OP_RD_IO,
      alht_pkg::OP_RD_COMM, alht_pkg::OP_SET_IO_POL, alht_pkg::OP_SET_LIM_POL, alht_pkg::OP_RD_LIM,
      alht_pkg::OP_RD_ADC, alht_pkg::OP_RD_GPIO, alht_pkg::OP_SET_GPIO: permit = 1'b1;
      default: permit = 1'b0;
    endcase
  endfunction

  // Pin inputs pass two flops
  alht_sync #(.W(16)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({io_trig, sw_home, sw_fwd, sw_rev}),
    .q(s_pins)
  );
  assign {s_io, s_home, s_fwd, s_rev} = s_pins;

  // Bus write channels latched independently
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid && !(aw_addr_r == alht_pkg::ADDR_CMD && rp_st_r != alht_pkg::RP_IDLE);
  assign host_go = wr_go && (aw_addr_r == alht_pkg::ADDR_CMD);
  assign stat_clr = s_axi_arvalid && s_axi_arready && (s_axi_araddr == alht_pkg::ADDR_STAT);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go || !aw_hold_r) begin
      aw_hold_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go || !w_hold_r) begin
      w_hold_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= alht_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_r == alht_pkg::ADDR_CMD || aw_addr_r == alht_pkg::ADDR_DATA || aw_addr_r == alht_pkg::ADDR_STAT ||
          aw_addr_r == alht_pkg::ADDR_LIMEN || aw_addr_r == alht_pkg::ADDR_SW) begin
        s_axi_bresp <= alht_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= alht_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Command argument word with byte strobes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_r <= 32'h0;
    end else if (wr_go && aw_addr_r == alht_pkg::ADDR_DATA) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_r[b]) begin
          data_r[8*b +: 8] <= w_data_r[8*b +: 8];
        end
      end
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = 32'h0;
    rd_ok = 1'b1;
    if (s_axi_araddr == alht_pkg::ADDR_CMD) begin
      rd_mux = 32'h0;
    end else if (s_axi_araddr == alht_pkg::ADDR_DATA) begin
      rd_mux = data_r;
    end else if (s_axi_araddr == alht_pkg::ADDR_STAT) begin
      rd_mux[alht_pkg::ST_FE] = fe_r;
      rd_mux[alht_pkg::ST_FNE] = fne_r;
      rd_mux[alht_pkg::ST_STORE] = store_r;
      rd_mux[alht_pkg::ST_SRCH] = (sr_st_r != alht_pkg::SR_IDLE);
      rd_mux[alht_pkg::ST_REPLAY] = (rp_st_r != alht_pkg::RP_IDLE);
      rd_mux[alht_pkg::ST_RUN +: 4] = mot_run;
      rd_mux[alht_pkg::ST_DIR +: 4] = mot_fwd;
      rd_mux[alht_pkg::ST_TRIG_EN +: 4] = trig_en_r;
      rd_mux[alht_pkg::ST_PEND +: 4] = pend_r;
    end else if (s_axi_araddr == alht_pkg::ADDR_LIMEN) begin
      rd_mux = {20'h0, limen_r};
    end else if (s_axi_araddr == alht_pkg::ADDR_SW) begin
      rd_mux = {20'h0, s_home, s_fwd, s_rev};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= alht_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? alht_pkg::RESP_OKAY : alht_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Armed, polarity-adjusted switch levels and their active edges
  always_comb begin
    for (int i = 0; i < NAX; i++) begin
      arm_fwd[i] = limen_r[alht_pkg::EN_LIM_TOP - 2*i] & ~(s_fwd[i] ^ pol_r[alht_pkg::EN_LIM_TOP - 2*i]);
      arm_rev[i] = limen_r[alht_pkg::EN_LIM_TOP - 1 - 2*i] & ~(s_rev[i] ^ pol_r[alht_pkg::EN_LIM_TOP - 1 - 2*i]);
      arm_home[i] = limen_r[alht_pkg::EN_HOME_TOP - i] & ~(s_home[i] ^ pol_r[alht_pkg::EN_HOME_TOP - i]);
    end
  end
  assign e_fwd = arm_fwd & ~q_fwd_r;
  assign e_rev = arm_rev & ~q_rev_r;
  assign e_home = arm_home & ~q_home_r;
  assign halt_ev = e_fwd | e_rev | e_home;
  assign blk = (mot_run & mot_fwd & arm_fwd) | (mot_run & ~mot_fwd & arm_rev);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q_fwd_r <= 4'h0;
      q_rev_r <= 4'h0;
      q_home_r <= 4'h0;
      s_io_q_r <= 4'h0;
    end else begin
      q_fwd_r <= arm_fwd;
      q_rev_r <= arm_rev;
      q_home_r <= arm_home;
      s_io_q_r <= s_io;
    end
  end

  // Current command: replay entry or host write
  assign c_v = (rp_st_r == alht_pkg::RP_RUN) || host_go;
  assign c_e = (rp_st_r == alht_pkg::RP_RUN) ? tb_rd[rp_buf_r] : {w_data_r[7:0], w_data_r[9:8], data_r};
  assign c_op = c_e[41:34];
  assign c_ax = c_e[33:32];
  assign c_dt = c_e[31:0];
  assign c_fwd = (c_dt == 32'h0);
  assign mv_block = c_fwd ? arm_fwd[c_ax] : arm_rev[c_ax];
  assign fh_dir = c_fwd ^ mv_block;

  // Dispatch: search gate, prestore capture, argument checks
  always_comb begin
    bad = 1'b0;
    fne_set = 1'b0;
    fe_set = 1'b0;
    tb_we = 4'h0;
    tb_clr = 4'h0;
    if (c_v) begin
      if (sr_st_r != alht_pkg::SR_IDLE && !permit(c_op)) begin
        bad = 1'b1;
        fne_set = 1'b1;
      end else if (store_r && c_op == alht_pkg::OP_BEGIN_PRE) begin
        bad = 1'b1;
        fe_set = 1'b1;
      end else if (store_r && c_op != alht_pkg::OP_END_PRE) begin
        bad = 1'b1;
        fe_set = tb_full[store_sel_r];
        tb_we[store_sel_r] = 1'b1;
      end else begin
        case (c_op)
          alht_pkg::OP_END_PRE: bad = !store_r;
          alht_pkg::OP_BEGIN_PRE: bad = (c_dt == 32'h0) || (c_dt > 32'h4);
          alht_pkg::OP_BRK_LINK: bad = (c_dt > 32'h4);
          alht_pkg::OP_TRIG_SW: bad = (c_dt == 32'h0) || (c_dt > 32'h4);
          alht_pkg::OP_MOVE: bad = mv_block;
          default: bad = 1'b0;
        endcase
        fe_set = bad;
        if (!bad && c_op == alht_pkg::OP_BEGIN_PRE) begin
          tb_clr[2'(c_dt[1:0] - 2'h1)] = 1'b1;
        end
      end
    end
  end
  assign do_x = c_v && !bad;

  // Executed commands go to the motion engine
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      exec_valid <= 1'b0;
      exec_op <= 8'h00;
      exec_axis <= 2'h0;
      exec_data <= 32'h0;
    end else begin
      exec_valid <= do_x;
      if (do_x) begin
        exec_op <= c_op;
        exec_axis <= c_ax;
        exec_data <= c_dt;
      end
    end
  end

  // Error flags: set wins over the read clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fe_r <= 1'b0;
      fne_r <= 1'b0;
    end else begin
      fe_r <= fe_set | (fe_r & ~stat_clr);
      fne_r <= fne_set | (fne_r & ~stat_clr);
    end
  end

  // Switch enable, polarity and trigger enable words
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      limen_r <= alht_pkg::EN_RST;
      pol_r <= alht_pkg::POL_RST;
      trig_en_r <= alht_pkg::TRIG_EN_RST;
    end else if (do_x) begin
      if (c_op == alht_pkg::OP_EN_LIMITS) begin
        limen_r <= c_dt[alht_pkg::EN_W-1:0];
      end
      if (c_op == alht_pkg::OP_SET_LIM_POL) begin
        pol_r <= c_dt[alht_pkg::EN_W-1:0];
      end
      if (c_op == alht_pkg::OP_EN_IO_TRIG) begin
        trig_en_r <= c_dt[3:0];
      end
    end
  end

  // Prestore mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      store_r <= 1'b0;
      store_sel_r <= 2'h0;
    end else if (do_x && c_op == alht_pkg::OP_BEGIN_PRE) begin
      store_r <= 1'b1;
      store_sel_r <= 2'(c_dt[1:0] - 2'h1);
    end else if (do_x && c_op == alht_pkg::OP_END_PRE) begin
      store_r <= 1'b0;
    end
  end

  // Trigger buffers
  for (genvar g = 0; g < NAX; g++) begin : g_tb
    alht_tbuf #(.DW(EW), .DEPTH(TB_DEPTH), .CW(CW)) u_tb (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clr(tb_clr[g]),
      .we(tb_we[g]),
      .wd(c_e),
      .ridx(rp_idx_r),
      .rd(tb_rd[g]),
      .count(tb_cnt[g]),
      .full(tb_full[g])
    );
  end

  // Breakpoint hits: position equals the armed target
  always_comb begin
    for (int i = 0; i < NAX; i++) begin
      brk_hit[i] = brk_en_r[i] && (axis_pos[i*POS_W +: POS_W] == brk_tgt_r[i]);
    end
  end

  // Breakpoint positions, targets and links
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      brk_en_r <= 4'h0;
      brk_out <= 4'h0;
      for (int i = 0; i < NAX; i++) begin
        link_r[i] <= alht_pkg::LINK_RST;
        brk_pos_r[i] <= '0;
        brk_tgt_r[i] <= '0;
      end
    end else begin
      brk_out <= brk_hit;
      for (int i = 0; i < NAX; i++) begin
        if (brk_hit[i]) begin
          brk_en_r[i] <= 1'b0;
        end
        if (do_x && c_ax == 2'(i)) begin
          if (c_op == alht_pkg::OP_LOAD_BRK) begin
            brk_pos_r[i] <= POS_W'(c_dt);
          end
          if (c_op == alht_pkg::OP_EN_BRK) begin
            brk_en_r[i] <= 1'b1;
            brk_tgt_r[i] <= c_fwd ? brk_pos_r[i] : brk_pos_r[i] + axis_pos[i*POS_W +: POS_W];
          end
          if (c_op == alht_pkg::OP_BRK_LINK) begin
            link_r[i] <= c_dt[2:0];
          end
        end
      end
    end
  end

  // Trigger sources for each buffer
  always_comb begin
    pend_set = s_io & ~s_io_q_r & trig_en_r;
    for (int i = 0; i < NAX; i++) begin
      if (brk_hit[i] && link_r[i] != 3'h0) begin
        pend_set[2'(link_r[i][1:0] - 2'h1)] = 1'b1;
      end
    end
    if (do_x && c_op == alht_pkg::OP_TRIG_SW) begin
      pend_set[2'(c_dt[1:0] - 2'h1)] = 1'b1;
    end
    pick = 2'h0;
    for (int k = NAX - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        pick = 2'(k);
      end
    end
    pick_oh = 4'h0;
    if (rp_st_r == alht_pkg::RP_IDLE && pend_r != 4'h0) begin
      pick_oh[pick] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= pend_set | (pend_r & ~pick_oh);
    end
  end

  // Replay a buffer one entry per cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rp_st_r <= alht_pkg::RP_IDLE;
      rp_buf_r <= 2'h0;
      rp_idx_r <= '0;
    end else begin
      case (rp_st_r)
        alht_pkg::RP_IDLE: begin
          rp_idx_r <= '0;
          rp_buf_r <= pick;
          if (pend_r != 4'h0 && tb_cnt[pick] != '0) begin
            rp_st_r <= alht_pkg::RP_RUN;
          end
        end
        alht_pkg::RP_RUN: begin
          rp_idx_r <= rp_idx_r + 1'b1;
          if (CW'(rp_idx_r + 1'b1) >= tb_cnt[rp_buf_r]) begin
            rp_st_r <= alht_pkg::RP_IDLE;
          end
        end
        default: rp_st_r <= alht_pkg::RP_IDLE;
      endcase
    end
  end

  // Home search sequence
  assign sr_revgo = (sr_st_r == alht_pkg::SR_OUT) && (sd_r ? e_fwd[sa_r] : e_rev[sa_r]) && !e_home[sa_r];

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sr_st_r <= alht_pkg::SR_IDLE;
      sa_r <= 2'h0;
      sd_r <= 1'b1;
    end else begin
      case (sr_st_r)
        alht_pkg::SR_IDLE: begin
          if (do_x && c_op == alht_pkg::OP_FIND_HOME) begin
            sa_r <= c_ax;
            sd_r <= c_fwd;
            sr_st_r <= mv_block ? alht_pkg::SR_BACK : alht_pkg::SR_OUT;
          end
        end
        alht_pkg::SR_OUT: begin
          if (sr_revgo) begin
            sr_st_r <= alht_pkg::SR_BACK;
          end else if (!mot_run[sa_r]) begin
            sr_st_r <= alht_pkg::SR_IDLE;
          end
        end
        alht_pkg::SR_BACK: begin
          if (!mot_run[sa_r]) begin
            sr_st_r <= alht_pkg::SR_IDLE;
          end
        end
        default: sr_st_r <= alht_pkg::SR_IDLE;
      endcase
    end
  end

  // Per-axis run and direction
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mot_run <= 4'h0;
      mot_fwd <= 4'h0;
      halt_stb <= 4'h0;
    end else begin
      for (int i = 0; i < NAX; i++) begin
        halt_stb[i] <= halt_ev[i] | (do_x && c_ax == 2'(i) && (c_op == alht_pkg::OP_KILL || c_op == alht_pkg::OP_STOP));
        if (sr_revgo && sa_r == 2'(i)) begin
          mot_run[i] <= 1'b1;
          mot_fwd[i] <= ~sd_r;
        end else if (halt_ev[i] || blk[i]) begin
          mot_run[i] <= 1'b0;
        end else if (do_x && c_ax == 2'(i)) begin
          if (c_op == alht_pkg::OP_KILL || c_op == alht_pkg::OP_STOP) begin
            mot_run[i] <= 1'b0;
          end else if (c_op == alht_pkg::OP_MOVE) begin
            mot_run[i] <= 1'b1;
            mot_fwd[i] <= c_fwd;
          end else if (c_op == alht_pkg::OP_FIND_HOME) begin
            mot_run[i] <= 1'b1;
            mot_fwd[i] <= fh_dir;
          end
        end
      end
    end
  end

  // Loaded velocity and acceleration, one 32-bit word per axis on mot_vel and mot_acc
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mot_vel <= 128'h0;
      mot_acc <= 128'h0;
    end else if (do_x) begin
      if (c_op == alht_pkg::OP_LOAD_VEL) begin
        mot_vel[c_ax*32 +: 32] <= c_dt;
      end
      if (c_op == alht_pkg::OP_LOAD_ACC) begin
        mot_acc[c_ax*32 +: 32] <= c_dt;
      end
    end
  end
endmodule

/* File: test/alht_sw_model.sv */
// Limit and home switch model driven by axis positions
`timescale 1ns/1ns
module alht_sw_model (
  input wire logic [127:0] axis_pos,
  output logic [3:0] sw_fwd,
  output logic [3:0] sw_rev,
  output logic [3:0] sw_home
);
  // Active-high switches: fwd at 100 up, rev at -100 down, home -20..-10
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sw_fwd[i] = $signed(axis_pos[i*32 +: 32]) >= 100;
      sw_rev[i] = $signed(axis_pos[i*32 +: 32]) <= -100;
      sw_home[i] = $signed(axis_pos[i*32 +: 32]) inside {[-20:-10]};
    end
  end
endmodule

/* File: test/alht_axis_seq_props.sv */
// Checker for bus handshakes and motion outputs
`timescale 1ns/1ns
module alht_axis_seq_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] mot_run,
  input wire logic [3:0] brk_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Both write channels taken together
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_wr_resp: assert property (s_wr_take |-> ##[1:40] s_axi_bvalid)
    else $error("write response missing");
  a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_aw_low: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready not lowered");
  a_ar_low: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("arready not lowered");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_brk_pulse: assert property (brk_out[0] |=> !brk_out[0])
    else $error("breakpoint not disarmed");
  a_reset_idle: assert property ($rose(rst_n) |-> mot_run == 4'h0 && !s_axi_bvalid)
    else $error("motion after reset");
endmodule
bind alht_axis_seq alht_axis_seq_props i_alht_axis_seq_props (.clk_sys, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .mot_run, .brk_out);

/* File: test/alht_axis_seq_tb.sv */
// Testbench: host command sequences against the sequencer
`timescale 1ns/1ns
module alht_axis_seq_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, p0 = 32'h0, rv, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [3:0] sw_fwd, sw_rev, sw_home, mot_run, mot_fwd, io_t = 4'h0;
  logic [127:0] mot_vel, mot_acc;
  int fail_count = 0, total_checks = 0, cyc = 0;
  alht_axis_seq i_alht_axis_seq (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sw_fwd, .sw_rev, .sw_home, .io_trig(io_t), .axis_pos({96'h0, p0}),
    .mot_run, .mot_fwd, .halt_stb(), .brk_out(), .mot_vel, .mot_acc, .exec_valid(), .exec_op(),
    .exec_axis(), .exec_data());
  alht_sw_model i_alht_sw_model (.axis_pos({96'h0, p0}), .sw_fwd, .sw_rev, .sw_home);
  // Clock and cycle ceiling
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: release each channel when taken, hold bready until bvalid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end while (s_axi_rready);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] d);
    wr(alht_pkg::ADDR_DATA, d);
    wr(alht_pkg::ADDR_CMD, {24'h0, op});
  endtask
  task automatic ck_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rv & m, e);
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    ck_rd(alht_pkg::ADDR_LIMEN, 32'hffffffff, 32'h0);
    ck_rd(alht_pkg::ADDR_STAT, 32'hffffffff, 32'h0);
    rd(8'h20);
    chk({30'h0, rr}, {30'h0, alht_pkg::RESP_SLVERR});
    cmd(alht_pkg::OP_SET_LIM_POL, 32'h0fff);
    cmd(alht_pkg::OP_EN_LIMITS, 32'hffff);
    ck_rd(alht_pkg::ADDR_LIMEN, 32'hffffffff, 32'h0fff);
    cmd(alht_pkg::OP_END_PRE, 32'h0);
    ck_rd(alht_pkg::ADDR_STAT, 32'h3, 32'h1);
    ck_rd(alht_pkg::ADDR_STAT, 32'h3, 32'h0);
    cmd(alht_pkg::OP_BEGIN_PRE, 32'h1);
    cmd(alht_pkg::OP_BEGIN_PRE, 32'h2);
    ck_rd(alht_pkg::ADDR_STAT, 32'h7, 32'h5);
    cmd(alht_pkg::OP_LOAD_VEL, 32'h55);
    cmd(alht_pkg::OP_END_PRE, 32'h0);
    chk(mot_vel[31:0], 32'h0);
    cmd(alht_pkg::OP_TRIG_SW, 32'h1);
    repeat (8) @(posedge clk_sys);
    chk(mot_vel[31:0], 32'h55);
    cmd(alht_pkg::OP_BEGIN_PRE, 32'h2);
    cmd(alht_pkg::OP_LOAD_ACC, 32'h77);
    cmd(alht_pkg::OP_END_PRE, 32'h0);
    cmd(alht_pkg::OP_BRK_LINK, 32'h2);
    cmd(alht_pkg::OP_LOAD_BRK, 32'h30);
    cmd(alht_pkg::OP_EN_BRK, 32'h0);
    p0 <= 32'h30;
    repeat (8) @(posedge clk_sys);
    chk(mot_acc[31:0], 32'h77);
    cmd(alht_pkg::OP_LOAD_ACC, 32'h0);
    chk(mot_acc[31:0], 32'h0);
    cmd(alht_pkg::OP_EN_IO_TRIG, 32'h2);
    io_t <= 4'h2;
    repeat (8) @(posedge clk_sys);
    chk(mot_acc[31:0], 32'h77);
    p0 <= 32'h0;
    cmd(alht_pkg::OP_FIND_HOME, 32'h0);
    chk({30'h0, mot_run[0], mot_fwd[0]}, 32'h3);
    cmd(alht_pkg::OP_MOVE, 32'h0);
    ck_rd(alht_pkg::ADDR_STAT, 32'h3, 32'h2);
    cmd(alht_pkg::OP_RD_POS, 32'h0);
    ck_rd(alht_pkg::ADDR_STAT, 32'hb, 32'h8);
    p0 <= 32'd100;
    repeat (8) @(posedge clk_sys);
    chk({30'h0, mot_run[0], mot_fwd[0]}, 32'h2);
    p0 <= 32'hfffffff1;
    repeat (8) @(posedge clk_sys);
    chk({31'h0, mot_run[0]}, 32'h0);
    p0 <= 32'd100;
    repeat (8) @(posedge clk_sys);
    cmd(alht_pkg::OP_MOVE, 32'h0);
    ck_rd(alht_pkg::ADDR_STAT, 32'h1, 32'h1);
    finish_test();
  end
endmodule
